/* File: hdl/gpio_pin_pkg.sv */
// Constants shared by the pin control block: offsets, field layout,
// reset values and the trigger and bus encodings.
// Assumes a 32-bit AHB-Lite register bus with word-aligned registers.
package gpio_pin_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [31:0] OFS_PIN_CONTROL = 32'h0000_006C; // Pad/function control
  localparam logic [31:0] OFS_IRQ_STATUS  = 32'h0000_0080; // Sticky pending, pin level
  localparam logic [31:0] OFS_IRQ_MASK    = 32'h0000_0084; // Gates the irq output

  // ----------------------------------------------------------------
  // Control register field positions
  // ----------------------------------------------------------------
  localparam int FWD_MASK_BIT  = 25; // Forward to interrupt controller
  localparam int TRIG_HI       = 23; // Trigger mode field
  localparam int TRIG_LO       = 21;
  localparam int IRQ_EN_BIT    = 20; // Pending generation enable
  localparam int DRV_HI        = 14; // Pad drive level field
  localparam int DRV_LO        = 12;
  localparam int PU_STRONG_BIT = 11; // 10K pull-up
  localparam int PD_WEAK_BIT   = 9;  // 100K pull-down
  localparam int PU_MED_BIT    = 8;  // 50K pull-up
  localparam int IN_EN_BIT     = 7;  // Pad input path
  localparam int OUT_EN_BIT    = 6;  // Pad output driver
  localparam int HYST_BIT      = 5;  // Schmitt input
  localparam int ANALOG_BIT    = 4;  // Route to analog channel
  localparam int FUNC_HI       = 3;  // Function select field
  localparam int FUNC_LO       = 0;

  // ----------------------------------------------------------------
  // Reset values and writable bits
  // ----------------------------------------------------------------
  localparam logic [31:0] CTL_RESET    = 32'h0000_1001; // Drive 0x1, function 0x1
  localparam logic [31:0] CTL_WR_MASK  = 32'h02F0_7BFF; // Reserved bits stay zero
  localparam logic [3:0]  FUNC_MAX     = 4'h8;          // Highest legal function code
  localparam int          STAT_PEND_BIT = 0;            // Status: interrupt pending
  localparam int          STAT_PIN_BIT  = 1;            // Status: synchronised pin level
  localparam int          MASK_IRQ_BIT  = 0;            // Mask: irq output enable

  // ----------------------------------------------------------------
  // Trigger modes and bus encodings
  // ----------------------------------------------------------------
  localparam logic [2:0] TRIG_RISE = 3'h0;
  localparam logic [2:0] TRIG_FALL = 3'h1;
  localparam logic [2:0] TRIG_BOTH = 3'h2;
  localparam logic [2:0] TRIG_HIGH = 3'h3;
  localparam logic [2:0] TRIG_LOW  = 3'h4;
  localparam int         HTRANS_ACTIVE_BIT = 1;   // NONSEQ or SEQ
  localparam logic [2:0] HSIZE_WORD = 3'h2;

  typedef enum logic [1:0] {
    BUS_IDLE,
    BUS_WR,
    BUS_RD
  } bus_state_t;

endpackage

/* File: hdl/pin_sync.sv */
// Multi-stage synchroniser for the pad input level.
// Assumes one clock; the first stage feeds only the second.
`timescale 1ns/1ps

module pin_sync #(
  parameter int STAGES = 2
) (
  input  wire logic clk,
  input  wire logic rstn,
  input  wire logic din,
  output wire logic dout
);

  // A single stage would leave the chain slice below empty
  if (STAGES < 2) begin : gen_bad_stages
    $error("STAGES must be at least 2");
  end

  logic [STAGES-1:0] sync_ff;   // Shift chain, index 0 is first stage
  logic [STAGES-1:0] nxt_sync;  // Next chain value

  // ----------------------------------------------------------------
  // Chain shift
  // ----------------------------------------------------------------
  always_comb begin
    nxt_sync = {sync_ff[STAGES-2:0], din};
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sync_ff <= '0;
    end else begin
      sync_ff <= nxt_sync;
    end
  end

  assign dout = sync_ff[STAGES-1];

endmodule

/* File: hdl/gpio_pin_control.sv */
// Control logic for one general-purpose pin behind an AHB-Lite slave.
// Assumes a single clock, single-word transfers and an external pad.
//
// What this block does
// - Mask bit gates request to interrupt controller
// - Trigger field selects edge or level mode
// - Enable low blocks pending and request
// - Enable high sets pending; mask gates request
// - Drive field picks one of eight levels
// - Pull-up and pull-down enables, reset off
// - Input, output and hysteresis enables, reset off
// - Analog bit routes pin to converter channel
// - Function field codes zero to eight, reset one
// - Control at 0x6C, reserved bits read zero
`timescale 1ns/1ps

module gpio_pin_control
  import gpio_pin_pkg::*;
#(
  parameter int SYNC_STAGES = 2
) (
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output wire logic        hreadyout,
  output wire logic        hresp,
  output wire logic [31:0] hrdata,
  input  wire logic        padIn,
  output wire logic [2:0]  driveStrength,
  output wire logic        pullupStrongEn,
  output wire logic        pulldownWeakEn,
  output wire logic        pullupMediumEn,
  output wire logic        inputPathEn,
  output wire logic        outputDriverEn,
  output wire logic        hysteresisEn,
  output wire logic        analogChannelEight,
  output wire logic [3:0]  functionSelect,
  output wire logic        controllerReq,
  output wire logic        irq
);

  // ----------------------------------------------------------------
  // Elaboration check
  // ----------------------------------------------------------------
  if (SYNC_STAGES < 2) begin : gen_bad_sync
    $error("SYNC_STAGES must be at least 2");
  end

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  bus_state_t  state_ff;      // Data phase in progress
  bus_state_t  nxt_state;
  logic [31:0] addr_ff;       // Latched address phase
  logic [31:0] nxt_addr;
  logic        ready_ff;      // Registered hreadyout
  logic        nxt_ready;
  logic [31:0] rdata_ff;      // Registered read data
  logic [31:0] nxt_rdata;
  logic [31:0] ctl_ff;        // Pin control register
  logic [31:0] nxt_ctl;
  logic        mask_ff;       // Irq output mask
  logic        nxt_mask;
  logic        pending_ff;    // Sticky interrupt pending
  logic        nxt_pending;
  logic        prevPin_ff;    // Previous synchronised sample
  logic        reqOut_ff;     // Request to interrupt controller
  logic        nxt_reqOut;
  logic        irq_ff;        // Level interrupt output
  logic        nxt_irq;
  logic        syncPin;       // Synchronised pad level
  logic        accept;        // Address phase taken this edge
  logic        trigEvent;     // Trigger event this cycle
  logic        ctlWrite;      // Control write commits this edge
  logic        statWrite;     // Status write commits this edge
  logic [31:0] rdMux;         // Read data before registering
  logic [3:0]  wrFunc;        // Function code being written

  // ----------------------------------------------------------------
  // Pad input synchroniser
  // ----------------------------------------------------------------
  pin_sync #(
    .STAGES (SYNC_STAGES)
  ) u_sync (
    .clk  (clk),
    .rstn (rstn),
    .din  (padIn),
    .dout (syncPin)
  );

  // ----------------------------------------------------------------
  // Bus slave: address decode and data phase
  // ----------------------------------------------------------------
  // Reads take one wait state so that read data come from a flop
  // and always reflect a write committed just before.
  always_comb begin
    accept    = hsel && hready && htrans[HTRANS_ACTIVE_BIT] && (hsize == HSIZE_WORD);
    nxt_state = BUS_IDLE;
    nxt_addr  = addr_ff;
    nxt_ready = 1'b1;
    nxt_rdata = rdata_ff;
    unique case (state_ff)
      BUS_IDLE: begin
        nxt_rdata = rdata_ff;             // Nothing pending
      end
      BUS_WR: begin
        nxt_rdata = rdata_ff;             // Commit handled below
      end
      BUS_RD: begin
        nxt_rdata = rdMux;                // Capture and release wait
      end
    endcase
    if (accept) begin
      nxt_addr = haddr;
      if (hwrite) begin
        nxt_state = BUS_WR;
      end else begin
        nxt_state = BUS_RD;
        nxt_ready = 1'b0;                 // One wait state for reads
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_ff <= BUS_IDLE;
      addr_ff  <= 32'h0000_0000;
      ready_ff <= 1'b1;
      rdata_ff <= 32'h0000_0000;
    end else begin
      state_ff <= nxt_state;
      addr_ff  <= nxt_addr;
      ready_ff <= nxt_ready;
      rdata_ff <= nxt_rdata;
    end
  end

  // ----------------------------------------------------------------
  // Read multiplexer
  // ----------------------------------------------------------------
  // Unmapped offsets read as zero with an OKAY answer.
  always_comb begin
    rdMux = 32'h0000_0000;
    if (addr_ff == OFS_PIN_CONTROL) begin
      rdMux = ctl_ff & CTL_WR_MASK;
    end else if (addr_ff == OFS_IRQ_STATUS) begin
      rdMux[STAT_PEND_BIT] = pending_ff;
      rdMux[STAT_PIN_BIT]  = syncPin;
    end else if (addr_ff == OFS_IRQ_MASK) begin
      rdMux[MASK_IRQ_BIT] = mask_ff;
    end
  end

  // ----------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------
  // A reserved function code is refused and the old one kept, so the
  // pad never sees an undefined mux select.
  always_comb begin
    ctlWrite  = (state_ff == BUS_WR) && (addr_ff == OFS_PIN_CONTROL);
    statWrite = (state_ff == BUS_WR) && (addr_ff == OFS_IRQ_STATUS);
    wrFunc    = hwdata[FUNC_HI:FUNC_LO];
    nxt_ctl   = ctl_ff;
    nxt_mask  = mask_ff;
    if (ctlWrite) begin
      nxt_ctl = hwdata & CTL_WR_MASK;
      if (wrFunc > FUNC_MAX) begin
        nxt_ctl[FUNC_HI:FUNC_LO] = ctl_ff[FUNC_HI:FUNC_LO];
      end
    end
    if ((state_ff == BUS_WR) && (addr_ff == OFS_IRQ_MASK)) begin
      nxt_mask = hwdata[MASK_IRQ_BIT];
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ctl_ff  <= CTL_RESET;
      mask_ff <= 1'b0;
    end else begin
      ctl_ff  <= nxt_ctl;
      mask_ff <= nxt_mask;
    end
  end

  // ----------------------------------------------------------------
  // Trigger detection
  // ----------------------------------------------------------------
  // Reserved trigger codes produce no event at all.
  always_comb begin
    trigEvent = 1'b0;
    unique case (ctl_ff[TRIG_HI:TRIG_LO])
      TRIG_RISE: trigEvent = syncPin && !prevPin_ff;
      TRIG_FALL: trigEvent = !syncPin && prevPin_ff;
      TRIG_BOTH: trigEvent = syncPin != prevPin_ff;
      TRIG_HIGH: trigEvent = syncPin;
      TRIG_LOW:  trigEvent = !syncPin;
      default:   trigEvent = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // Pending flag, request and interrupt
  // ----------------------------------------------------------------
  // Set wins over a write-one clear in the same cycle; in level modes
  // the flag re-sets at once while the level persists.
  always_comb begin
    nxt_pending = pending_ff;
    if (statWrite && hwdata[STAT_PEND_BIT]) begin
      nxt_pending = 1'b0;
    end
    if (trigEvent && ctl_ff[IRQ_EN_BIT]) begin
      nxt_pending = 1'b1;
    end
    nxt_reqOut = pending_ff && ctl_ff[IRQ_EN_BIT] && ctl_ff[FWD_MASK_BIT];
    nxt_irq    = pending_ff && mask_ff;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pending_ff <= 1'b0;
      prevPin_ff <= 1'b0;
      reqOut_ff  <= 1'b0;
      irq_ff     <= 1'b0;
    end else begin
      pending_ff <= nxt_pending;
      prevPin_ff <= syncPin;
      reqOut_ff  <= nxt_reqOut;
      irq_ff     <= nxt_irq;
    end
  end

  // ----------------------------------------------------------------
  // Outputs, all straight from flops except hresp, which is tied low
  // ----------------------------------------------------------------
  // Analog routing is signalled to the pad; one pin per channel is
  // left to software, the block does not police it.
  assign hreadyout          = ready_ff;
  assign hresp              = 1'b0;
  assign hrdata             = rdata_ff;
  assign driveStrength      = ctl_ff[DRV_HI:DRV_LO];
  assign pullupStrongEn     = ctl_ff[PU_STRONG_BIT];
  assign pulldownWeakEn     = ctl_ff[PD_WEAK_BIT];
  assign pullupMediumEn     = ctl_ff[PU_MED_BIT];
  assign inputPathEn        = ctl_ff[IN_EN_BIT];
  assign outputDriverEn     = ctl_ff[OUT_EN_BIT];
  assign hysteresisEn       = ctl_ff[HYST_BIT];
  assign analogChannelEight = ctl_ff[ANALOG_BIT];
  assign functionSelect     = ctl_ff[FUNC_HI:FUNC_LO];
  assign controllerReq      = reqOut_ff;
  assign irq                = irq_ff;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  sequence s_readTaken;
    accept && !hwrite;
  endsequence

  sequence s_readAnswer;
    !hreadyout ##1 hreadyout;
  endsequence

  sequence s_riseSeen;
    !prevPin_ff && syncPin && (ctl_ff[TRIG_HI:TRIG_LO] == TRIG_RISE);
  endsequence

  // Falling edge seen in falling mode
  sequence s_fallSeen;
    prevPin_ff && !syncPin && (ctl_ff[TRIG_HI:TRIG_LO] == TRIG_FALL);
  endsequence

  AST_READ_WAIT: assert property (@(posedge clk) disable iff (!rstn)
    s_readTaken |=> s_readAnswer)
    else $error("Read answer not after one wait state");

  AST_MASK_GATES: assert property (@(posedge clk) disable iff (!rstn)
    controllerReq |-> $past(ctl_ff[FWD_MASK_BIT]))
    else $error("Request sent while forwarding masked");

  AST_RISE_PENDS: assert property (@(posedge clk) disable iff (!rstn)
    s_riseSeen and ctl_ff[IRQ_EN_BIT] |=> pending_ff)
    else $error("Rising edge did not set pending");

  AST_NO_PEND_OFF: assert property (@(posedge clk) disable iff (!rstn)
    $rose(pending_ff) |-> $past(ctl_ff[IRQ_EN_BIT]))
    else $error("Pending set while enable low");

  AST_REQ_FOLLOWS: assert property (@(posedge clk) disable iff (!rstn)
    pending_ff && ctl_ff[IRQ_EN_BIT] && ctl_ff[FWD_MASK_BIT] |=> controllerReq)
    else $error("Unmasked pending not forwarded");

  AST_DRIVE_WR: assert property (@(posedge clk) disable iff (!rstn)
    ctlWrite |=> driveStrength == $past(hwdata[DRV_HI:DRV_LO]))
    else $error("Drive field not written");

  AST_PULL_WR: assert property (@(posedge clk) disable iff (!rstn)
    ctlWrite |=> pullupStrongEn == $past(hwdata[PU_STRONG_BIT])
             && pulldownWeakEn == $past(hwdata[PD_WEAK_BIT])
             && pullupMediumEn == $past(hwdata[PU_MED_BIT]))
    else $error("Pull enables not written");

  AST_PAD_WR: assert property (@(posedge clk) disable iff (!rstn)
    ctlWrite |=> outputDriverEn == $past(hwdata[OUT_EN_BIT])
             && hysteresisEn == $past(hwdata[HYST_BIT])
             && inputPathEn == $past(hwdata[IN_EN_BIT]))
    else $error("Pad enables not written");

  AST_ANALOG_WR: assert property (@(posedge clk) disable iff (!rstn)
    ctlWrite |=> analogChannelEight == $past(hwdata[ANALOG_BIT]))
    else $error("Analog select not written");

  AST_FUNC_REFUSE: assert property (@(posedge clk) disable iff (!rstn)
    ctlWrite && (hwdata[FUNC_HI:FUNC_LO] > FUNC_MAX) |=> $stable(functionSelect))
    else $error("Reserved function code accepted");

  AST_RSVD_ZERO: assert property (@(posedge clk) disable iff (!rstn)
    (ctl_ff & ~CTL_WR_MASK) == 32'h0000_0000)
    else $error("Reserved control bit set");

  AST_LEVEL_HOLDS: assert property (@(posedge clk) disable iff (!rstn)
    ((ctl_ff[TRIG_HI:TRIG_LO] == TRIG_HIGH) && syncPin && ctl_ff[IRQ_EN_BIT])
    [*2] |-> pending_ff)
    else $error("High level did not keep pending");

  AST_FALL_PENDS: assert property (@(posedge clk) disable iff (!rstn)
    s_fallSeen and ctl_ff[IRQ_EN_BIT] |=> pending_ff)
    else $error("Falling edge did not set pending");

  AST_LOW_PENDS: assert property (@(posedge clk) disable iff (!rstn)
    (ctl_ff[TRIG_HI:TRIG_LO] == TRIG_LOW) && !syncPin && ctl_ff[IRQ_EN_BIT] |=> pending_ff)
    else $error("Low level did not set pending");

  // Reserved codes are stored but must stay inert
  AST_RSVD_TRIG: assert property (@(posedge clk) disable iff (!rstn)
    (ctl_ff[TRIG_HI:TRIG_LO] > TRIG_LOW) && !pending_ff |=> !pending_ff)
    else $error("Reserved trigger mode raised pending");

  AST_NO_REQ_OFF: assert property (@(posedge clk) disable iff (!rstn)
    !ctl_ff[IRQ_EN_BIT] |=> !controllerReq)
    else $error("Request sent while enable low");

  // Clear only takes effect when no enabled event collides with it
  AST_PEND_CLEAR: assert property (@(posedge clk) disable iff (!rstn)
    statWrite && hwdata[STAT_PEND_BIT] && !trigEvent |=> !pending_ff)
    else $error("Write-one did not clear pending");

endmodule

/* File: verification/pad_irq_model.sv */
// Behavioural model of the pad that feeds this pin's input level.
// Assumes the bench commands the wanted level and that one clock exists.
`timescale 1ns/1ps

module pad_irq_model (
  input  wire logic clk,
  input  wire logic rstn,
  input  wire logic padLevel,
  output logic      padIn
);
  // ----------------------------------------------------------------
  // Pad level
  // ----------------------------------------------------------------
  // Only this one pin is modelled, so it alone may claim the analog channel
  // Level moves just after an edge, never in the sampling instant
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      padIn <= 1'b0;
    end else begin
      padIn <= padLevel;
    end
  end
endmodule

/* File: verification/tb_gpio_pin_control.sv */
// Self-checking bench for the pin control block and its register bus.
// Assumes one AHB-Lite master (this bench) and the pad model as partner.
`timescale 1ns/1ps

module tb_gpio_pin_control;
  import gpio_pin_pkg::*;

`define CHK(g, e, m) begin comparisons++; if ((g) !== (e)) begin errorCnt++; \
  $display("[FAIL] %0t %s", $time, m); end end

  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic        clk = 1'b0;           // 50 MHz system clock
  logic        rstn = 1'b0;          // Async reset, active low
  logic        hsel = 1'b0;          // Bus select
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] hwdata = 32'h0000_0000;
  wire  logic  hreadyout;            // Single slave: also the bus ready
  wire  logic  hresp;
  wire  logic [31:0] hrdata;
  logic        padLevel = 1'b0;      // Level commanded to the pad model
  wire  logic  padIn;
  wire  logic [2:0] driveStrength;
  wire  logic  pullupStrongEn, pulldownWeakEn, pullupMediumEn, inputPathEn;
  wire  logic  outputDriverEn, hysteresisEn, analogChannelEight, controllerReq, irq;
  wire  logic [3:0] functionSelect;
  int          errorCnt = 0;         // Mismatches
  int          comparisons = 0;      // Checks made
  logic [31:0] rd;                   // Last read word

  always #10 clk = ~clk;

  gpio_pin_control dut_u (.clk(clk), .rstn(rstn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .padIn(padIn),
    .driveStrength(driveStrength), .pullupStrongEn(pullupStrongEn),
    .pulldownWeakEn(pulldownWeakEn), .pullupMediumEn(pullupMediumEn),
    .inputPathEn(inputPathEn), .outputDriverEn(outputDriverEn),
    .hysteresisEn(hysteresisEn), .analogChannelEight(analogChannelEight),
    .functionSelect(functionSelect), .controllerReq(controllerReq), .irq(irq));

  pad_irq_model pad_u (.clk(clk), .rstn(rstn), .padLevel(padLevel), .padIn(padIn));

  // ----------------------------------------------------------------
  // Bus tasks: entered and left just after a rising edge
  // ----------------------------------------------------------------
  task automatic endOfTest;
    $display("TB checks %0d, errors %0d", comparisons, errorCnt);
    if (errorCnt == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Bounded wait for hready seen high at an edge
  task automatic wait_rdy;
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (hreadyout !== 1'b1 && n < 20);
    if (n >= 20) begin
      errorCnt++;
      $display("[FAIL] %0t bus hang", $time);
      endOfTest();
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
    hsel   <= 1'b1;
    haddr  <= a;
    htrans <= 2'h2;
    hwrite <= wr;
    hsize  <= HSIZE_WORD;
    wait_rdy();
    // Select drops with the address phase, so a next call may raise it
    htrans <= 2'h0;
    hsel   <= 1'b0;
    hwdata <= d;
    wait_rdy();
    rd = hrdata;
    `CHK(hresp, 1'b0, "response not okay")
  endtask

  // Pad enables packed high bit first: 11, 9, 8, 7, 6, 5, 4
  function automatic logic [6:0] pads();
    return {pullupStrongEn, pulldownWeakEn, pullupMediumEn, inputPathEn,
            outputDriverEn, hysteresisEn, analogChannelEight};
  endfunction

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic reset_values;
    bus(1'b0, 32'h0000_006C, 32'h0000_0000);
    `CHK(rd, 32'h0000_1001, "control reset value")
    `CHK(driveStrength, 3'h1, "drive reset")
    `CHK(functionSelect, 4'h1, "function reset")
    `CHK(pads(), 7'h00, "pad enables reset")
    `CHK({controllerReq, irq}, 2'h0, "interrupt reset")
  endtask

  task automatic field_map;
    int bits[7] = '{11, 9, 8, 7, 6, 5, 4};
    bus(1'b1, 32'h0000_006C, 32'hFFFF_FFFF);
    bus(1'b0, 32'h0000_006C, 32'h0000_0000);
    `CHK(rd, 32'h02F0_7BF1, "reserved bits or function code")
    `CHK(functionSelect, 4'h1, "reserved function kept")
    for (int i = 0; i < 7; i++) begin
      bus(1'b1, 32'h0000_006C, 32'h0000_1001 | (32'h0000_0001 << bits[i]));
      cyc(1);                        // Write lands at the last bus edge
      `CHK(pads(), 7'h40 >> i, "pad enable bit map")
    end
    for (int i = 0; i < 9; i++) begin
      bus(1'b1, 32'h0000_006C, (i[31:0] & 32'h0000_0007) << 12 | i[31:0]);
      cyc(1);                        // Write lands at the last bus edge
      `CHK({driveStrength, functionSelect}, {i[2:0], i[3:0]}, "drive or function")
    end
    bus(1'b1, 32'h0000_0010, 32'hFFFF_FFFF);
    bus(1'b0, 32'h0000_0010, 32'h0000_0000);
    `CHK(rd, 32'h0000_0000, "unmapped read")
    bus(1'b0, 32'h0000_006C, 32'h0000_0000);
    `CHK(rd, 32'h0000_0008, "control after unmapped write")
  endtask

  // One trigger trial: settle, clear pending, move the pad, judge
  task automatic trig(input logic [2:0] m, input logic en, input logic fwd,
                      input logic s, input logic p);
    padLevel <= s;
    cyc(5);
    bus(1'b1, 32'h0000_006C, {6'h00, fwd, 1'b0, m, en, 20'h0_1001});
    cyc(4);
    bus(1'b1, 32'h0000_0080, 32'h0000_0001);
    cyc(2);
    bus(1'b0, 32'h0000_0080, 32'h0000_0000);
    `CHK(rd, {30'h0000_0000, s, 1'b0}, "pending not cleared")
    padLevel <= ~s;
    cyc(6);
    bus(1'b0, 32'h0000_0080, 32'h0000_0000);
    `CHK(rd, {30'h0000_0000, ~s, p}, "pending after pad move")
    `CHK(controllerReq, p & fwd, "controller request")
    `CHK(irq, p, "irq output")
  endtask

  task automatic trigger_modes;
    bus(1'b1, 32'h0000_0084, 32'h0000_0001);
    bus(1'b0, 32'h0000_0084, 32'h0000_0000);
    `CHK(rd, 32'h0000_0001, "irq mask readback")
    trig(TRIG_RISE, 1'b1, 1'b1, 1'b0, 1'b1);
    trig(TRIG_RISE, 1'b1, 1'b1, 1'b1, 1'b0);
    trig(TRIG_FALL, 1'b1, 1'b1, 1'b1, 1'b1);
    trig(TRIG_BOTH, 1'b1, 1'b1, 1'b0, 1'b1);
    trig(TRIG_BOTH, 1'b1, 1'b1, 1'b1, 1'b1);
    trig(TRIG_HIGH, 1'b1, 1'b0, 1'b0, 1'b1);
    trig(TRIG_LOW,  1'b1, 1'b1, 1'b1, 1'b1);
    trig(3'h5,      1'b1, 1'b1, 1'b0, 1'b0);
    trig(TRIG_RISE, 1'b0, 1'b1, 1'b0, 1'b0);
    trig(TRIG_RISE, 1'b1, 1'b1, 1'b0, 1'b1);
  endtask

  // Pending left set above: mask, unmask, then clear
  task automatic irq_mask_clear;
    bus(1'b1, 32'h0000_0084, 32'h0000_0000);
    cyc(2);
    `CHK({irq, controllerReq}, 2'h1, "masked irq")
    bus(1'b1, 32'h0000_0084, 32'h0000_0001);
    cyc(2);
    `CHK(irq, 1'b1, "unmasked irq")
    bus(1'b1, 32'h0000_0080, 32'h0000_0001);
    cyc(2);
    `CHK({irq, controllerReq}, 2'h0, "cleared irq")
  endtask

  // Reset in mid-run after writing all ones to control; the reserved function code 0xF is refused and kept at one
  task automatic mid_reset;
    bus(1'b1, 32'h0000_006C, 32'hFFFF_FFFF);
    rstn <= 1'b0;
    cyc(3);
    rstn <= 1'b1;
    cyc(1);
    reset_values();
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    reset_values();
    field_map();
    trigger_modes();
    irq_mask_clear();
    mid_reset();
    endOfTest();
  end
endmodule
